// ==== rtl/tms_scan_seq.sv ====
// Scan sequencer for an 8x8 capacitive touch-key matrix.
// Assumes an external gating PLD, analog front end and 8-bit ADC port.
`timescale 1ns/1ps
module tms_scan_seq #(
    parameter logic [6:0] KEY_CAP = tms_pkg::CAP_64
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic [2:0] spacing_sel,
    input wire tms_pkg::tms_cfg_t cfg,
    input wire logic calibrating,
    input wire logic [7:0] adc_data,
    output tms_pkg::tms_pins_t pins,
    output logic adc_start,
    output tms_pkg::tms_result_t result,
    output logic cfg_refused
);

    // ******************************
    // Checks and memories
    // ******************************
    if (KEY_CAP != tms_pkg::CAP_32 && KEY_CAP != tms_pkg::CAP_48 && KEY_CAP != tms_pkg::CAP_64) begin : g_bad_cap
        $error("tms_scan_seq: unsupported key capacity");
    end

    logic [6:0] burst_mem [tms_pkg::KEYS];
    logic [7:0] offset_mem [tms_pkg::KEYS];
    logic [1:0] cancel_mem [tms_pkg::KEYS];

    typedef struct packed {
        tms_pkg::tms_state_t st;
        logic [2:0] row;
        logic [2:0] col;
        logic [6:0] pulses;
        logic [7:0] timer;
        logic [6:0] enabled;
        logic skip;
        logic pend;
        tms_pkg::tms_pins_t pins;
        logic adc_start;
        tms_pkg::tms_result_t result;
        logic refused;
    } tms_seq_t;

    tms_seq_t s_q, s_d;
    logic tick;
    logic [5:0] cur_key;
    logic [6:0] cur_burst;
    logic cfg_ok;
    logic [6:0] new_count;

    // Key index is column-major: col * 8 + row
    function automatic logic [5:0] key_of(input logic [2:0] c, input logic [2:0] r);
        key_of = {c, r};
    endfunction

    function automatic logic [7:0] one_hot(input logic [2:0] i);
        one_hot = 8'h01 << i;
    endfunction

    tms_tick_div u_div (
        .mclk(mclk),
        .rst(rst),
        .spacing_sel(spacing_sel),
        .tick(tick)
    );

    assign cur_key = key_of(s_q.col, s_q.row);
    assign cur_burst = burst_mem[cur_key];

    // ******************************
    // Configuration writes
    // ******************************
    always_comb begin
        new_count = s_q.enabled;
        if (burst_mem[cfg.key] != 7'h0)
            new_count = new_count - 7'h1;
        if (cfg.burst != 7'h0)
            new_count = new_count + 7'h1;
        cfg_ok = (new_count <= KEY_CAP) && (cfg.burst <= tms_pkg::BURST_MAX);
    end

    // Higher keys start disabled on reduced variants; offsets and cancel steps reset to zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int k = 0; k < tms_pkg::KEYS; k++) begin
                burst_mem[k] <= (7'(k) < KEY_CAP) ? 7'h01 : 7'h00;
                offset_mem[k] <= 8'h00;
                cancel_mem[k] <= 2'h0;
            end
        end else if (cfg.wr && cfg_ok) begin
            burst_mem[cfg.key] <= cfg.burst;
            cancel_mem[cfg.key] <= cfg.cancel;
            if (cfg.recal && calibrating)
                offset_mem[cfg.key] <= cfg.offset;
        end
    end

    // ******************************
    // Scan state machine
    // ******************************
    always_comb begin
        s_d = s_q;
        s_d.adc_start = 1'b0;
        s_d.result.valid = 1'b0;
        s_d.refused = cfg.wr && !cfg_ok;
        s_d.pend = s_q.pend | tick;
        if (cfg.wr && cfg_ok)
            s_d.enabled = new_count;
        if (s_q.timer != 8'h0)
            s_d.timer = s_q.timer - 8'h1;
        case (s_q.st)
            tms_pkg::ST_IDLE: begin
                s_d.pins.integ_reset = 1'b1;
                s_d.pins.cancel_drive = tms_pkg::CANCEL_IDLE;
                if (run && s_q.pend) begin
                    s_d.pend = tick;
                    s_d.pins.mux_select = s_q.col;
                    s_d.skip = (cur_burst == 7'h0);
                    s_d.pins.column_gate_lines = (cur_burst == 7'h0) ? 8'h00 : one_hot(s_q.col);
                    s_d.pulses = cur_burst;
                    s_d.timer = 8'(tms_pkg::RESET_CYC);
                    s_d.st = tms_pkg::ST_RESET;
                end
            end
            tms_pkg::ST_RESET: begin
                if (s_q.timer == 8'h0) begin
                    s_d.pins.integ_reset = 1'b0;
                    s_d.st = s_q.skip ? tms_pkg::ST_WAIT : tms_pkg::ST_GATE;
                end
            end
            tms_pkg::ST_GATE: begin
                s_d.pins.gate_trigger_out = 1'b1;
                s_d.st = tms_pkg::ST_RISE;
            end
            tms_pkg::ST_RISE: begin
                s_d.pins.row_drive = one_hot(s_q.row);
                s_d.pins.gate_trigger_out = 1'b0;
                s_d.timer = 8'(tms_pkg::PULSE_SPACING_CYC / 2);
                s_d.st = tms_pkg::ST_FALL;
            end
            tms_pkg::ST_FALL: begin
                if (s_q.timer == 8'h0) begin
                    s_d.pins.row_drive = 8'h00;
                    s_d.pulses = s_q.pulses - 7'h1;
                    if (s_q.pulses == (cur_burst >> 1))
                        s_d.pins.cancel_drive = ~cancel_mem[cur_key];
                    s_d.timer = 8'(tms_pkg::PULSE_SPACING_CYC / 2);
                    s_d.st = (s_q.pulses == 7'h1) ? tms_pkg::ST_OFFSET : tms_pkg::ST_WAIT;
                end
            end
            tms_pkg::ST_OFFSET: begin
                s_d.pins.row_drive = offset_mem[cur_key];
                s_d.timer = 8'(tms_pkg::SETTLE_CYC);
                s_d.st = tms_pkg::ST_SAMPLE;
            end
            tms_pkg::ST_SAMPLE: begin
                if (s_q.timer == 8'h0) begin
                    s_d.adc_start = 1'b1;
                    s_d.result.valid = 1'b1;
                    s_d.result.key = cur_key;
                    s_d.result.value = adc_data;
                    s_d.pins.row_drive = 8'h00;
                    s_d.st = tms_pkg::ST_WAIT;
                    s_d.skip = 1'b1;
                end
            end
            tms_pkg::ST_WAIT: begin
                // Burst done (or skipped): advance key; pulses re-enter gate
                if (s_q.timer == 8'h0) begin
                    if (!s_q.skip && s_q.pulses != 7'h0) begin
                        s_d.st = tms_pkg::ST_GATE;
                    end else begin
                        s_d.pins.column_gate_lines = 8'h00;
                        s_d.pins.integ_reset = 1'b1;
                        s_d.pins.cancel_drive = tms_pkg::CANCEL_IDLE;
                        s_d.row = s_q.row + 3'h1;
                        if (s_q.row == 3'h7)
                            s_d.col = s_q.col + 3'h1;
                        s_d.st = tms_pkg::ST_IDLE;
                    end
                end
            end
            default: s_d.st = tms_pkg::ST_IDLE;
        endcase
        if (!run) begin
            s_d.row = 3'h0;
            s_d.col = 3'h0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.pins.cancel_drive <= tms_pkg::CANCEL_IDLE;
            s_q.pins.integ_reset <= 1'b1;
            s_q.enabled <= KEY_CAP;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins = s_q.pins;
    assign adc_start = s_q.adc_start;
    assign result = s_q.result;
    assign cfg_refused = s_q.refused;
endmodule

// ==== rtl/tms_pkg.sv ====
// Package for the touch matrix scan sequencer: constants and carriers.
// Assumes a single 50 MHz clock; shared by the sequencer and its divider.
package tms_pkg;

    // ******************************
    // Clock and timing
    // ******************************
    localparam int CLK_HZ = 50000000;
    localparam int PULSE_SPACING_NS = 2000;
    localparam int PULSE_SPACING_CYC = (PULSE_SPACING_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int RESET_NS = 1000;
    localparam int RESET_CYC = (RESET_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int SPACING_MIN_US = 250;
    localparam int SPACING_MAX_US = 2000;
    localparam int SPACING_MIN_CYC = SPACING_MIN_US * (CLK_HZ / 1000000);
    localparam int SPACING_MAX_CYC = SPACING_MAX_US * (CLK_HZ / 1000000);
    localparam int SPACING_STEP_CYC = SPACING_MIN_CYC;

    // ******************************
    // Matrix geometry
    // ******************************
    localparam int ROWS = 8;
    localparam int COLS = 8;
    localparam int KEYS = ROWS * COLS;
    localparam logic [6:0] BURST_MAX = 7'h40;
    localparam logic [6:0] CAP_32 = 7'h20;
    localparam logic [6:0] CAP_48 = 7'h30;
    localparam logic [6:0] CAP_64 = 7'h40;
    localparam logic [1:0] CANCEL_IDLE = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RESET = 3'b001,
        ST_GATE = 3'b010,
        ST_RISE = 3'b011,
        ST_FALL = 3'b100,
        ST_OFFSET = 3'b101,
        ST_SAMPLE = 3'b110,
        ST_WAIT = 3'b111
    } tms_state_t;

    typedef struct packed {
        logic [2:0] mux_select;
        logic [7:0] column_gate_lines;
        logic gate_trigger_out;
        logic integ_reset;
        logic [1:0] cancel_drive;
        logic [7:0] row_drive;
    } tms_pins_t;

    typedef struct packed {
        logic valid;
        logic [5:0] key;
        logic [7:0] value;
    } tms_result_t;

    typedef struct packed {
        logic wr;
        logic [5:0] key;
        logic [6:0] burst;
        logic [7:0] offset;
        logic [1:0] cancel;
        logic recal;
    } tms_cfg_t;

endpackage

// ==== rtl/tms_tick_div.sv ====
// Burst spacing divider: one-cycle start pulse every programmed interval.
// Assumes a single clock; spacing selection comes from same-clock logic.
`timescale 1ns/1ps
module tms_tick_div #(
    parameter int SPACING_MAX = tms_pkg::SPACING_MAX_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] spacing_sel,
    output logic tick
);
    typedef struct packed {
        logic [16:0] cnt;
        logic tick;
    } tms_div_t;

    tms_div_t s_q, s_d;
    logic [16:0] limit;

    // Counter is 17 bits wide, so longer spacings cannot be served
    if (SPACING_MAX > 131071 || SPACING_MAX < tms_pkg::SPACING_MIN_CYC) begin : g_bad_spacing
        $error("tms_tick_div: spacing out of range");
    end

    // Sel 0..7 gives 250 us steps up to 2 ms
    always_comb begin
        limit = 17'((32'(spacing_sel) + 32'h1) * 32'(tms_pkg::SPACING_STEP_CYC) - 32'h1);
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= limit) begin
            s_d.cnt = 17'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 17'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// ==== verification/tms_scan_seq_asserts.sv ====
// Checker on the scan sequencer top ports, bound below.
// Assumes one mclk domain and rst async active high.
`timescale 1ns/1ps
module tms_scan_seq_asserts #(
    parameter logic [6:0] KEY_CAP = tms_pkg::CAP_64
) (
    input wire logic mclk,
    input wire logic rst,
    input wire tms_pkg::tms_cfg_t cfg,
    input wire tms_pkg::tms_pins_t pins,
    input wire logic cfg_refused
);
    // ****************
    // Helper counter
    // ****************
    logic [7:0] npulse_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            npulse_q <= 8'h00;
        end else if (pins.integ_reset) begin
            npulse_q <= 8'h00;
        end else if (pins.gate_trigger_out) begin
            npulse_q <= npulse_q + 8'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_cancel_idle; pins.integ_reset |-> pins.cancel_drive == tms_pkg::CANCEL_IDLE; endproperty
    a_cancel_idle: assert property (p_cancel_idle) else $error("cancel drive low while idle");
    property p_gate_onehot; $onehot0(pins.column_gate_lines); endproperty
    a_gate_onehot: assert property (p_gate_onehot) else $error("several column gates high");
    property p_gate_mux; |pins.column_gate_lines |-> pins.column_gate_lines == (8'h01 << pins.mux_select); endproperty
    a_gate_mux: assert property (p_gate_mux) else $error("column gate and select disagree");
    property p_trig_row; pins.gate_trigger_out |=> $onehot(pins.row_drive) && !pins.gate_trigger_out; endproperty
    a_trig_row: assert property (p_trig_row) else $error("no single row after trigger");
    property p_trig_space; pins.gate_trigger_out |=> !pins.gate_trigger_out [*8]; endproperty
    a_trig_space: assert property (p_trig_space) else $error("row pulses too close");
    property p_trig_gate; pins.gate_trigger_out |-> |pins.column_gate_lines; endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger without column gate");
    property p_sel_stable; !pins.integ_reset && !$past(pins.integ_reset) |-> $stable(pins.column_gate_lines)
        && $stable(pins.mux_select); endproperty
    a_sel_stable: assert property (p_sel_stable) else $error("column changed in burst");
    property p_row_quiet; pins.integ_reset |-> pins.row_drive == 8'h00; endproperty
    a_row_quiet: assert property (p_row_quiet) else $error("row driven between bursts");
    property p_burst_max; npulse_q <= {1'b0, tms_pkg::BURST_MAX}; endproperty
    a_burst_max: assert property (p_burst_max) else $error("burst too long");
    property p_refuse; cfg.wr && cfg.burst > tms_pkg::BURST_MAX |-> ##[1:2] cfg_refused; endproperty
    a_refuse: assert property (p_refuse) else $error("long burst not refused");
endmodule

bind tms_scan_seq tms_scan_seq_asserts #(.KEY_CAP(KEY_CAP)) u_chk (.mclk(mclk), .rst(rst), .cfg(cfg),
    .pins(pins), .cfg_refused(cfg_refused));

// ==== verification/tms_afe_model.sv ====
// Analog front end and gating logic model feeding the ADC input.
// Assumes pins from the sequencer; value valid only after charge seen.
`timescale 1ns/1ps
module tms_afe_model (
    input wire logic mclk,
    input wire tms_pkg::tms_pins_t pins,
    output logic [7:0] adc_data
);
    logic [7:0] junk_q = 8'h55;
    logic charged_q = 1'b0;
    // Mux open from trigger through the row rise of the gated column
    wire mux_open = pins.gate_trigger_out | (|pins.row_drive & |pins.column_gate_lines);
    // Unselected columns clamped, so only the open mux adds charge
    wire [7:0] col_clamp = ~(pins.column_gate_lines & {8{mux_open}});
    always @(posedge mclk) begin
        junk_q <= ~junk_q;
        charged_q <= !pins.integ_reset && (charged_q || (mux_open && col_clamp != 8'hFF));
    end
    // Floating input otherwise, so toggle rather than hold
    assign adc_data = charged_q ? (8'hC3 ^ {pins.mux_select, 5'h00}) : junk_q;
endmodule

// ==== verification/tb_top.sv ====
// Testbench: reset, config refusal and a short scan of the sequencer.
// Assumes 50 MHz mclk and the front end model on the ADC input.
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic [2:0] spacing_sel = 3'h0;
    logic calibrating = 1'b0;
    tms_pkg::tms_cfg_t cfg = '0;
    tms_pkg::tms_pins_t pins;
    tms_pkg::tms_result_t result;
    logic [7:0] adc_data;
    logic adc_start, cfg_refused, trig_q = 1'b0, got2 = 1'b0;
    int n_mismatch = 0, total_checks = 0, cyc = 0, n_adc = 0;
    int npl[64], first_t[64];
    logic [5:0] res_key[$];
    logic [7:0] res_val[$];
    logic [7:0] res_off[$];
    logic [1:0] res_cz[$];
    logic [7:0] prev_row = 8'h00;
    always #10 mclk = ~mclk;
    tms_scan_seq #(.KEY_CAP(tms_pkg::CAP_32)) u_dut (.mclk(mclk), .rst(rst), .run(run),
        .spacing_sel(spacing_sel), .cfg(cfg), .calibrating(calibrating), .adc_data(adc_data),
        .pins(pins), .adc_start(adc_start), .result(result), .cfg_refused(cfg_refused));
    tms_afe_model u_afe (.mclk(mclk), .pins(pins), .adc_data(adc_data));
    // ****************
    // Monitor
    // ****************
    always @(negedge mclk) begin
        cyc++;
        if (trig_q) begin
            npl[{pins.mux_select, 3'($clog2(pins.row_drive))}]++;
            if (first_t[{pins.mux_select, 3'($clog2(pins.row_drive))}] == 0)
                first_t[{pins.mux_select, 3'($clog2(pins.row_drive))}] = cyc;
        end
        trig_q = pins.gate_trigger_out;
        if (adc_start === 1'b1)
            n_adc++;
        // Row pins carried the offset in the cycle before the sample
        if (result.valid === 1'b1) begin
            res_key.push_back(result.key);
            res_val.push_back(result.value);
            res_off.push_back(prev_row);
            res_cz.push_back(pins.cancel_drive);
            got2 = got2 | (result.key === 6'h02);
        end
        prev_row = pins.row_drive;
    end
    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr_cfg(input logic [5:0] key, input logic [6:0] burst, input logic [7:0] off,
        input logic [1:0] cz, input logic exp_ref);
        logic r1;
        @(negedge mclk);
        cfg = '{1'b1, key, burst, off, cz, 1'b1};
        @(negedge mclk);
        r1 = cfg_refused;
        cfg.wr = 1'b0;
        @(negedge mclk);
        chk(32'(r1 | cfg_refused), 32'(exp_ref), "cfg refusal");
    endtask
    task automatic t_reset;
        chk(32'({pins.column_gate_lines, pins.gate_trigger_out, pins.integ_reset, pins.cancel_drive,
            pins.row_drive}), 32'({8'h00, 1'b0, 1'b1, 2'h3, 8'h00}), "reset pins");
        $display("test reset done");
    endtask
    task automatic t_refuse;
        wr_cfg(6'h00, 7'h41, 8'h00, 2'h0, 1'b1);
        wr_cfg(6'h28, 7'h01, 8'h00, 2'h0, 1'b1);
        wr_cfg(6'h01, 7'h00, 8'h00, 2'h0, 1'b0);
        wr_cfg(6'h28, 7'h01, 8'h00, 2'h0, 1'b0);
        wr_cfg(6'h29, 7'h01, 8'h00, 2'h0, 1'b1);
        // Offset request outside calibration must be ignored
        wr_cfg(6'h00, 7'h03, 8'h5A, 2'h0, 1'b0);
        calibrating = 1'b1;
        wr_cfg(6'h02, 7'h40, 8'hA5, 2'h1, 1'b0);
        calibrating = 1'b0;
        $display("test refuse done");
    endtask
    task automatic t_scan;
        run = 1'b1;
        for (int i = 0; i < 60000 && !got2; i++) @(negedge mclk);
        if (!got2) begin
            n_mismatch++;
            $display("[FAIL] %0t scan timeout", $time);
        end else begin
            chk(32'(npl[0]), 32'd3, "key0 pulses");
            chk(32'(npl[1]), 32'd0, "key1 pulses");
            chk(32'(npl[2]), 32'd64, "key2 pulses");
            chk(32'(first_t[2] - first_t[0]), 32'(2 * tms_pkg::SPACING_MIN_CYC), "slot timing");
            chk(32'(res_key[0]), 32'h00, "first key");
            chk(32'(res_key[$]), 32'h02, "row order");
            chk(32'(res_val[0]), 32'hC3, "key0 value");
            chk(32'(res_val[$]), 32'hC3, "key2 value");
            chk(32'(res_key.size()), 32'd2, "result count");
            chk(32'(n_adc), 32'd2, "adc starts");
            chk(32'(res_off[0]), 32'h00, "key0 offset kept");
            chk(32'(res_off[$]), 32'hA5, "key2 offset");
            chk(32'(res_cz[0]), 32'h3, "key0 cancel idle");
            chk(32'(res_cz[$]), 32'h2, "key2 cancel step");
        end
        $display("test scan done");
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        t_reset();
        rst = 1'b0;
        t_refuse();
        t_scan();
        end_sim();
    end
endmodule
